// [logic/csc_regs.svh]
// constants of the card supply class and answer-to-reset block
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// answer-to-reset characters
`define CSC_TS          8'h3b
`define CSC_T0_Y1       4'h9
`define CSC_HIST_CNT    4'h7
`define CSC_TA1         8'h95
`define CSC_TD1         8'h80
`define CSC_TD2         8'h1f
`define CSC_CAT_IND     8'h80
`define CSC_TAG_SVC     8'h31
`define CSC_SVC_DATA    8'ha0
`define CSC_TAG_CAP     8'h73
`define CSC_CAP_D1      8'h80
`define CSC_CAP_D2      8'h21
`define CSC_CAP_D3      8'h40
`define CSC_CLK_STOP    2'h3
`define CSC_LAST_IDX    4'hc
`define CSC_TCK_IDX     4'hd

// supply class field of the class byte
`define CSC_CLASS_W     5
`define CSC_CLASS_DFLT  5'h03

// timing, in link clock edges and elementary time units
`define CSC_ETU_372_1   9'h174
`define CSC_ETU_512_8   9'h040
`define CSC_ETU_512_16  9'h020
`define CSC_ATR_DELAY   9'h190
`define CSC_FRAME_BITS  4'ha
`define CSC_GUARD_ETU   4'h2

// data buffer
`define CSC_FIFO_DEPTH  32
`define CSC_FIFO_MARGIN 6'h1e

`endif

// [logic/csc_pkg.sv]
// types of the card supply class and answer-to-reset block
package csc_pkg;

  // rate factor pair in use after the answer
  typedef enum logic [1:0] {RATE_372_1, RATE_512_8, RATE_512_16} csc_rate_t;

  // exchange phase after the reset contact
  typedef enum logic [1:0] {PH_HOLD, PH_DELAY, PH_LOAD, PH_RUN} csc_phase_t;

  // character transmitter
  typedef enum logic [1:0] {TX_IDLE, TX_BIT, TX_GUARD} csc_tx_t;

  // one buffered character, answer or user
  typedef struct packed {
    logic       user;
    logic [7:0] data;
  } csc_word_t;

  // whole state of the top module
  typedef struct packed {
    logic [2:0] clk_sync;
    logic [1:0] rst_sync;
    logic [1:0] io_sync;
    csc_phase_t phase;
    logic [8:0] dly;
    logic [3:0] idx;
    logic [7:0] tck;
    csc_tx_t    tx;
    logic [3:0] bit_n;
    logic [8:0] etu_cnt;
    logic [8:0] etu_len;
    logic [9:0] frame;
    logic       io_out;
    logic       io_oe;
    logic       atr_done;
    logic       in_ready;
  } csc_state_t;

endpackage

// [logic/csc_card_atr.sv]
// card side answer-to-reset sender with supply class report and data buffer
// Function
// [R01] terminal first powers at its lowest class
// [R02] no answer: terminal retries one class up
// [R03] unlisted class: terminal moves to listed class
// [R04] corrupted answer: three retries same class
// [R05] then only next higher class allowed
// [R06] class byte bits zero..four mark A..E
// [R07] supported classes form one adjacent run
// [R08] terminal accepts all interface and historical bytes
// [R09] answer carries the T=15 global characters
// [R10] first historical byte is category 80
// [R11] service object 31 then capabilities 73
// [R12] support 372/1, 512/8 and 512/16 rates
// [R13] terminal starts negotiation for other rates
// [R14] first TA byte states supported rate factors
// [R15] answer is first string after reset
// [R16] terminal finishes class switching before anything else
// [R17] missing announced characters mean protocol error
// [R18] terminal rejects: card off, host flag
// [R19] terminal picks lowest common class
`timescale 1ns/1ps
`include "csc_regs.svh"

// buffer of characters between the loader and the line
module csc_fifo #(
  parameter int W = 9,
  parameter int D = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clear,
  // filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  // fill level
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);

  // whole buffer state
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } csc_fifo_st_t;

  csc_fifo_st_t st_reg;   // registered state
  csc_fifo_st_t st_next;  // next state
  logic         push;     // write this cycle
  logic         pop;      // read this cycle

  // honest flags from the count
  assign in_ready  = (st_reg.cnt != (AW+1)'(D));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data  = st_reg.mem[st_reg.rp];
  assign count     = st_reg.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next.wp  = '0;
      st_next.rp  = '0;
      st_next.cnt = '0;
    end else begin
      if (push) begin
        st_next.mem[st_reg.wp] = in_data;
        st_next.wp             = st_reg.wp + 1'b1;
      end
      if (pop) begin
        st_next.rp = st_reg.rp + 1'b1;
      end
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // csc_fifo

// card end of the contact interface
module csc_card_atr #(
  parameter logic [`CSC_CLASS_W-1:0] CLASS_SUPPORT = `CSC_CLASS_DFLT
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // card contacts
  input  wire logic              card_clk,
  input  wire logic              card_rst_n,
  input  wire logic              io_in,
  output logic                   io_out,
  output logic                   io_oe,
  // rate chosen after negotiation
  input  wire csc_pkg::csc_rate_t rate_sel,
  // user data stream toward the terminal
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire logic [7:0]        tx_data,
  // status
  output logic                   atr_done
);
  csc_pkg::csc_state_t s_reg;   // registered state
  csc_pkg::csc_state_t s_next;  // next state
  csc_pkg::csc_word_t  f_in;    // word into the buffer
  csc_pkg::csc_word_t  f_out;   // word out of the buffer
  logic                f_in_valid;
  logic                f_in_ready;
  logic                f_out_valid;
  logic                f_out_ready;
  logic                f_clear;
  logic [5:0]          f_count;
  logic [`CSC_CLASS_W-1:0] cls;  // class field sent

  // lowest set bit of a class field
  function automatic logic [`CSC_CLASS_W-1:0] low_bit(input logic [`CSC_CLASS_W-1:0] c);
    low_bit = c & (~c + 1'b1);
  endfunction

  // keep a contiguous run, else only the lowest class
  function automatic logic [`CSC_CLASS_W-1:0] class_fix(input logic [`CSC_CLASS_W-1:0] c);
    logic [`CSC_CLASS_W:0] sum;
    sum = {1'b0, c} + {1'b0, low_bit(c)};
    if ((sum[`CSC_CLASS_W-1:0] & c) == '0) begin
      class_fix = c;  // [R07]
    end else begin
      class_fix = low_bit(c);  // [R07]
    end
  endfunction

  // link clocks per elementary time unit
  function automatic logic [8:0] etu_of(input csc_pkg::csc_rate_t r);
    case (r)
      csc_pkg::RATE_512_8:  etu_of = `CSC_ETU_512_8;   // [R12]
      csc_pkg::RATE_512_16: etu_of = `CSC_ETU_512_16;  // [R12]
      default:              etu_of = `CSC_ETU_372_1;   // [R12]
    endcase
  endfunction

  // answer-to-reset character by position
  function automatic logic [7:0] atr_byte(input logic [3:0] i, input logic [`CSC_CLASS_W-1:0] c);
    case (i)
      4'h0:    atr_byte = `CSC_TS;
      4'h1:    atr_byte = {`CSC_T0_Y1, `CSC_HIST_CNT};
      4'h2:    atr_byte = `CSC_TA1;                            // [R14]
      4'h3:    atr_byte = `CSC_TD1;
      4'h4:    atr_byte = `CSC_TD2;                            // [R09]
      4'h5:    atr_byte = {`CSC_CLK_STOP, 1'b0, c};            // [R06]
      4'h6:    atr_byte = `CSC_CAT_IND;                        // [R10]
      4'h7:    atr_byte = `CSC_TAG_SVC;                        // [R11]
      4'h8:    atr_byte = `CSC_SVC_DATA;
      4'h9:    atr_byte = `CSC_TAG_CAP;                        // [R11]
      4'ha:    atr_byte = `CSC_CAP_D1;
      4'hb:    atr_byte = `CSC_CAP_D2;
      default: atr_byte = `CSC_CAP_D3;
    endcase
  endfunction

  assign cls = class_fix(CLASS_SUPPORT);

  // character buffer
  csc_fifo #(
    .W ($bits(csc_pkg::csc_word_t)),
    .D (`CSC_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .clear     (f_clear),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out),
    .count     (f_count)
  );

  // buffer feed: answer bytes first, user bytes only afterwards
  always_comb begin
    f_clear    = (s_reg.phase == csc_pkg::PH_HOLD);
    f_in       = '0;
    f_in_valid = 1'b0;
    if (s_reg.phase == csc_pkg::PH_LOAD) begin
      f_in_valid = 1'b1;
      f_in.data  = (s_reg.idx == `CSC_TCK_IDX) ? s_reg.tck : atr_byte(s_reg.idx, cls);
    end else if (s_reg.phase == csc_pkg::PH_RUN) begin
      f_in_valid = tx_valid & s_reg.in_ready;  // [R15]
      f_in.user  = 1'b1;
      f_in.data  = tx_data;
    end
  end

  // line idle and a character waiting
  assign f_out_ready = (s_reg.tx == csc_pkg::TX_IDLE) && (s_reg.phase != csc_pkg::PH_HOLD) && s_reg.io_sync[1];

  // next state of sync, loader and transmitter
  always_comb begin
    logic tick;
    logic edge_seen;
    tick      = 1'b0;
    edge_seen = 1'b0;
    s_next    = s_reg;
    // two-stage synchronisers and edge memory
    s_next.clk_sync = {s_reg.clk_sync[1], s_reg.clk_sync[0], card_clk};
    s_next.rst_sync = {s_reg.rst_sync[0], card_rst_n};
    s_next.io_sync  = {s_reg.io_sync[0], io_in};
    edge_seen = s_reg.clk_sync[1] & ~s_reg.clk_sync[2];
    // elementary time unit counter
    if (s_reg.tx != csc_pkg::TX_IDLE && edge_seen) begin
      if (s_reg.etu_cnt == s_reg.etu_len - 1'b1) begin
        s_next.etu_cnt = '0;
        tick           = 1'b1;
      end else begin
        s_next.etu_cnt = s_reg.etu_cnt + 1'b1;
      end
    end
    // exchange phase
    case (s_reg.phase)
      csc_pkg::PH_HOLD: begin
        s_next.dly      = '0;
        s_next.idx      = '0;
        s_next.tck      = '0;
        s_next.atr_done = 1'b0;
        if (s_reg.rst_sync[1]) begin
          s_next.phase = csc_pkg::PH_DELAY;
        end
      end
      csc_pkg::PH_DELAY: begin
        if (edge_seen) begin
          s_next.dly = s_reg.dly + 1'b1;
        end
        if (s_reg.dly == `CSC_ATR_DELAY) begin
          s_next.phase = csc_pkg::PH_LOAD;
        end
      end
      csc_pkg::PH_LOAD: begin
        // check byte is the xor of all bytes after the initial one
        if (f_in_ready) begin
          s_next.idx = s_reg.idx + 1'b1;
          if (s_reg.idx != '0) begin
            s_next.tck = s_reg.tck ^ f_in.data;  // [R09]
          end
          if (s_reg.idx == `CSC_TCK_IDX) begin
            s_next.phase    = csc_pkg::PH_RUN;
            s_next.atr_done = 1'b1;  // [R15]
          end
        end
      end
      csc_pkg::PH_RUN: begin
        s_next.phase = csc_pkg::PH_RUN;
      end
      default: begin
        s_next.phase = csc_pkg::PH_HOLD;
      end
    endcase
    // user side may write only with room to spare
    s_next.in_ready = (s_next.phase == csc_pkg::PH_RUN) && (f_count < `CSC_FIFO_MARGIN);  // [R15]
    // character transmitter
    case (s_reg.tx)
      csc_pkg::TX_IDLE: begin
        s_next.io_oe = 1'b0;
        if (f_out_ready && f_out_valid) begin
          s_next.tx      = csc_pkg::TX_BIT;
          s_next.bit_n   = '0;
          s_next.etu_cnt = '0;
          s_next.frame   = {^f_out.data, f_out.data, 1'b0};
          s_next.etu_len = f_out.user ? etu_of(rate_sel) : `CSC_ETU_372_1;  // [R12]
          s_next.io_oe   = 1'b1;
        end
      end
      csc_pkg::TX_BIT: begin
        if (tick) begin
          if (s_reg.bit_n == `CSC_FRAME_BITS - 1'b1) begin
            s_next.tx    = csc_pkg::TX_GUARD;
            s_next.bit_n = '0;
            s_next.io_oe = 1'b0;
          end else begin
            s_next.bit_n = s_reg.bit_n + 1'b1;
            s_next.frame = {1'b1, s_reg.frame[9:1]};
            s_next.io_oe = ~s_reg.frame[1];
          end
        end
      end
      csc_pkg::TX_GUARD: begin
        s_next.io_oe = 1'b0;
        if (tick) begin
          s_next.bit_n = s_reg.bit_n + 1'b1;
          if (s_reg.bit_n == `CSC_GUARD_ETU - 1'b1) begin
            s_next.tx = csc_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        s_next.tx    = csc_pkg::TX_IDLE;
        s_next.io_oe = 1'b0;
      end
    endcase
    // reset contact low stops everything and releases the line
    if (!s_reg.rst_sync[1]) begin
      s_next.phase    = csc_pkg::PH_HOLD;
      s_next.tx       = csc_pkg::TX_IDLE;
      s_next.io_oe    = 1'b0;
      s_next.in_ready = 1'b0;
      s_next.atr_done = 1'b0;
    end
    s_next.io_out = 1'b0;
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign io_out   = s_reg.io_out;
  assign io_oe    = s_reg.io_oe;
  assign tx_ready = s_reg.in_ready;
  assign atr_done = s_reg.atr_done;
endmodule // csc_card_atr

// [sim/csc_card_atr_assertions.sv]
// checker of the card answer-to-reset sender at its ports
`timescale 1ns/1ps
module csc_card_atr_checker (
  // clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // card contacts
  input wire logic               card_clk,
  input wire logic               card_rst_n,
  input wire logic               io_in,
  input wire logic               io_out,
  input wire logic               io_oe,
  // user stream and status
  input wire csc_pkg::csc_rate_t rate_sel,
  input wire logic               tx_valid,
  input wire logic               tx_ready,
  input wire logic [7:0]         tx_data,
  input wire logic               atr_done
);
  localparam int MIN_WAIT = 6300; // 400 card clocks of 16 cycles, less phase slack
  localparam int MIN_BIT  = 500;  // shortest bit, 32 card clocks, less sync jitter
  int   up;   // cycles since the reset contact went high
  int   run;  // cycles since the line driver last changed
  logic oe_q; // line driver one cycle ago
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // saturating helper counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up   <= 0;
      run  <= 0;
      oe_q <= 1'b0;
    end else begin
      up   <= !card_rst_n ? 0 : (up < MIN_WAIT ? up + 1 : up);
      run  <= (io_oe != oe_q) ? 0 : (run < MIN_BIT ? run + 1 : run);
      oe_q <= io_oe;
    end
  end
  AST_FIRST_WAIT: assert property (io_oe && !oe_q |-> up >= MIN_WAIT)
    else $error("character started too early after reset contact");
  AST_HOLD_QUIET: assert property ((!card_rst_n) [*6] |-> !io_oe)
    else $error("line driven while reset contact low");
  AST_READY_NEEDS_DONE: assert property (tx_ready |-> atr_done)
    else $error("user byte taken before answer complete");
  AST_DONE_CLEARS: assert property ($fell(card_rst_n) |-> ##[1:6] !atr_done)
    else $error("answer status kept through reset contact");
  AST_READY_CLEARS: assert property ($fell(card_rst_n) |-> ##[1:6] !tx_ready)
    else $error("ready kept through reset contact");
  AST_BIT_LEN: assert property ((io_oe != oe_q) && card_rst_n |-> run >= MIN_BIT)
    else $error("bit shorter than the fastest rate");
  AST_DONE_ONLY_RESET: assert property ($fell(atr_done) |-> !card_rst_n)
    else $error("answer status dropped without reset contact");
  AST_DONE_LATE: assert property ($rose(atr_done) |-> up >= MIN_WAIT)
    else $error("answer status before the start delay");
  // main scenarios
  cover property ($rose(atr_done));
  cover property (tx_valid && !tx_ready && atr_done);
  cover property ($fell(card_rst_n) && !atr_done);
endmodule // csc_card_atr_checker

bind csc_card_atr csc_card_atr_checker i_chk (.clk(clk), .rst(rst), .card_clk(card_clk), .card_rst_n(card_rst_n),
  .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .rate_sel(rate_sel), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_data(tx_data), .atr_done(atr_done));

// [sim/csc_term_model.sv]
// terminal model: clocks and resets the card, receives its characters
`timescale 1ns/1ps
module csc_term_model (
  // bench control
  input  wire logic       act,
  input  wire logic       hold,
  input  wire logic [8:0] etu,
  // card contacts
  output logic            card_clk,
  output logic            card_rst_n,
  output logic            io_in,
  input  wire logic       io_out,
  input  wire logic       io_oe,
  // received character, frame error on top
  output logic            rx_v,
  output logic [8:0]      rx_d
);
  logic [10:0] sh; // start, data, parity, guard samples
  assign io_in      = io_oe ? io_out : 1'b1; // pull-up unless the card drives
  assign card_rst_n = ~hold;
  // card clock stands still while not activated
  initial card_clk = 1'b0;
  always #40 card_clk = act & ~card_clk;
  // receiver takes every character, of any kind
  initial rx_v = 1'b0;
  always begin
    @(negedge io_in);
    repeat (etu / 2) @(posedge card_clk);
    for (int k = 0; k < 11; k++) begin
      sh[k] = io_in;
      repeat (etu) @(posedge card_clk);
    end
    rx_d = {sh[0] | ~sh[10] | ^sh[9:1], sh[8:1]}; // bad start, guard or parity
    rx_v = 1'b1;
    #1 rx_v = 1'b0;
  end
endmodule // csc_term_model

// [sim/tb_top.sv]
// testbench of the card answer-to-reset sender against a terminal model
`timescale 1ns/1ps
`include "csc_regs.svh"
module tb_top;
  logic               clk, rst, act, hold, card_clk, card_rst_n, io_in, io_out, io_oe;
  logic               tx_valid, tx_ready, atr_done, rx_v, refused;
  logic [7:0]         tx_data;
  logic [8:0]         etu, rx_d;
  csc_pkg::csc_rate_t rate_sel;
  logic [8:0]         got[$];  // received characters, error flag on top
  logic [7:0]         sent[$]; // accepted user bytes
  int                 fails, n_tests, seed, cyc, i, r;
  csc_card_atr #(.CLASS_SUPPORT(5'h1a)) i_dut (.clk(clk), .rst(rst), .card_clk(card_clk),
    .card_rst_n(card_rst_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .rate_sel(rate_sel),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .atr_done(atr_done));
  csc_term_model i_term (.act(act), .hold(hold), .etu(etu), .card_clk(card_clk), .card_rst_n(card_rst_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .rx_v(rx_v), .rx_d(rx_d));
  // clock and collection of characters
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  always @(posedge rx_v) got.push_back(rx_d);
  // watchdog
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // offer n random bytes back to back, note refusals
  task automatic send(input int n);
    repeat (n) begin
      tx_valid <= 1'b1;
      tx_data  <= 8'($random(seed));
      @(negedge clk);
      while (!tx_ready) begin
        refused = 1'b1;
        @(negedge clk);
      end
      sent.push_back(tx_data);
      @(posedge clk);
    end
    tx_valid <= 1'b0;
  endtask
  // expected answer, check byte folded over bytes 1 to 12
  function automatic logic [7:0] exp_atr(input int k);
    logic [7:0] t[14];
    t = '{`CSC_TS, 8'h97, `CSC_TA1, `CSC_TD1, `CSC_TD2, {2'h3, 1'b0, 5'h02}, 8'h80, 8'h31,
          `CSC_SVC_DATA, 8'h73, `CSC_CAP_D1, `CSC_CAP_D2, `CSC_CAP_D3, 8'h00};
    for (int j = 1; j < 13; j++) t[13] ^= t[j];
    return t[k];
  endfunction
  // supported classes form one run of set bits
  function automatic logic run_ok(input logic [4:0] c);
    while (c != 5'h00 && !c[0]) c = c >> 1;
    return c != 5'h00 && ((c + 5'h01) & c) == 5'h00;
  endfunction
  // terminal's retry class: lowest class that both sides offer
  function automatic logic [4:0] pick_cls(input logic [4:0] card, input logic [4:0] term);
    logic [4:0] both;
    both = card & term;
    return both & (~both + 5'h01);
  endfunction
  initial begin
    seed     = 32'h8dba;
    rst      = 1'b1;
    act      = 1'b0;
    hold     = 1'b1;
    etu      = 9'h174;
    rate_sel = csc_pkg::RATE_372_1;
    tx_valid = 1'b0;
    tx_data  = 8'h00;
    refused  = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    act <= 1'b1; // supply settled before clock and reset activity
    repeat (200) @(posedge clk);
    tx_valid <= 1'b1;
    hold     <= 1'b0;
    // abort after the first character, a cut answer: retry at the same class
    wait (got.size() == 1);
    @(posedge clk);
    hold <= 1'b1;
    repeat (400) @(posedge clk);
    chk({7'h00, atr_done, tx_ready}, 9'h000);
    chk(got[0], {1'b0, `CSC_TS});
    got.delete();
    hold <= 1'b0;
    repeat (100) @(posedge clk);
    chk({8'h00, tx_ready}, 9'h000);
    tx_valid <= 1'b0;
    // full answer content
    wait (got.size() == 14);
    @(posedge clk);
    for (i = 0; i < 14; i++) chk(got[i], {1'b0, exp_atr(i)});
    chk({8'h00, run_ok(got[5][4:0])}, 9'h001);
    // terminal offers A to C and tried A first; card lists no A, so one class up
    chk({4'h0, pick_cls(got[5][4:0], 5'h07)}, 9'h002);
    chk({8'h00, atr_done}, 9'h001);
    got.delete();
    // user bytes at every mandatory rate pair, so no negotiation is started
    for (r = 0; r < 3; r++) begin
      rate_sel <= csc_pkg::csc_rate_t'(r);
      etu      <= r == 0 ? 9'h174 : (r == 1 ? 9'h040 : 9'h020); // 372, 512/8, 512/16 clocks a bit
      @(posedge clk);
      send(r == 0 ? 1 : ($random(seed) & 3) + 1);
      wait (got.size() == sent.size());
      @(posedge clk);
    end
    // fill the buffer until it refuses, then drain it
    refused = 1'b0;
    send(32);
    chk({8'h00, refused}, 9'h001);
    wait (got.size() == sent.size());
    for (i = 0; i < sent.size(); i++) chk(got[i], {1'b0, sent[i]});
    // warm reset after traffic: answer first again, at the default rate despite rate_sel
    got.delete();
    @(posedge clk);
    hold <= 1'b1; // reset contact held low for a while, card clock kept running
    repeat (400) @(posedge clk);
    chk({7'h00, atr_done, tx_ready}, 9'h000);
    etu  <= 9'h174;
    hold <= 1'b0;
    wait (got.size() == 1);
    @(posedge clk);
    chk(got[0], {1'b0, `CSC_TS});
    finish_test();
  end
endmodule // tb_top
